/* verilog/psb_map.vh */
/*
  Constants for the pseudo-SRAM burst transition block: register offsets,
  configuration and status fields, reset values, state codes and timings.
  Assumes inclusion by bare name from the design files.
*/
// Notes on behaviour
// - Async write may chain into fixed burst read
// - Fixed burst read may chain into async write
// - Burst interruptible only after first data word
// - Variable latency code two gives four clocks
// - Active-low wait held through delay, drops at data
// - Burst write wait lasts latency code cycles, one cycle for code zero
// - Refresh collision stretches variable read wait up to double
`ifndef PSB_MAP_VH
`define PSB_MAP_VH

// Register offsets
`define PSB_REG_CFG 2'h0
`define PSB_REG_STAT 2'h1

// Configuration fields
`define PSB_CFG_RST 16'h9800
`define PSB_CFG_OPMODE 15
`define PSB_CFG_FIXED 14
`define PSB_CFG_LC_HI 13
`define PSB_CFG_LC_LO 11
`define PSB_CFG_WPOL 10
`define PSB_CFG_WEARLY 8

// Status fields
`define PSB_ST_CEM 0
`define PSB_ST_CPH 1
`define PSB_ST_TRANS 2
`define PSB_ST_INTR 3
`define PSB_ST_ERR_W 4
`define PSB_ST_STATE_LO 4
`define PSB_ST_REFR 6
`define PSB_ST_WAIT 7

// Synchronised pin vector layout
`define PSB_PIN_W 24
`define PSB_PIN_RST 24'h00000F
`define PSB_P_CE 0
`define PSB_P_AV 1
`define PSB_P_WE 2
`define PSB_P_OE 3
`define PSB_P_A_LO 4
`define PSB_P_A_HI 7
`define PSB_P_D_LO 8
`define PSB_P_D_HI 23

// Machine states
`define PSB_S_IDLE 2'h0
`define PSB_S_LAT 2'h1
`define PSB_S_DATA 2'h2

// Last operation codes
`define PSB_OP_NONE 3'h0
`define PSB_OP_AWR 3'h1
`define PSB_OP_ARD 3'h2
`define PSB_OP_BRD_FIX 3'h3
`define PSB_OP_BURST 3'h4

// Latency offsets over the code
`define PSB_LAT_FIX_ADD 5'h01
`define PSB_LAT_VAR_ADD 5'h02

// Timing
`define PSB_CLK_MHZ 40
`define PSB_MIN_ENABLE_HIGH_TIME_NS 5
`define PSB_TREFOP_NS 15

`endif

/* verilog/psb_wbuf.v */
/*
  Two-entry buffer with valid and ready on both sides, flip-flop storage.
  Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module psb_wbuf (
  // Clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire flush_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [15:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [15:0] out_data_o
);
  reg [15:0] ent_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;
  genvar g;

  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = ent_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Entry storage
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ent
      always @(posedge ref_clk_i) begin
        if (clk_en_i && push && (wp_r == g)) begin
          ent_r[g] <= in_data_i;
        end
      end
    end
  endgenerate

  // Pointers and fill count
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || (clk_en_i && flush_i)) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (clk_en_i) begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

/* verilog/psb_core.v */
/*
  Device-side burst control of a pseudo-SRAM: latency and wait generation,
  burst interrupt, async/burst transitions, refresh opportunity watch,
  small flop array and a register port for configuration and status.
  Assumes memory bus pins arrive from outside the clock domain and the
  register port runs on ref_clk_i.
*/
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "psb_map.vh"
module psb_core #(
  parameter MAX_ENABLE_LOW_TIME_NS = 4000,
  parameter REFRESH_CYC = 64
) (
  // Clock, reset, enable
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // Register port
  input wire [1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // Memory bus control pins
  input wire mem_ce_n_i,
  input wire addr_valid_n_i,
  input wire mem_we_n_i,
  input wire mem_oe_n_i,
  input wire [3:0] mem_addr_i,
  // Data pins
  input wire [15:0] dq_i,
  output reg [15:0] dq_o,
  output reg dq_oe_n_o,
  // Wait pin
  output reg wait_o,
  output reg wait_oe_n_o
);
  localparam [31:0] CEM_CYC = (MAX_ENABLE_LOW_TIME_NS * `PSB_CLK_MHZ) / 1000;
  localparam [31:0] CPH_RAW = (`PSB_MIN_ENABLE_HIGH_TIME_NS * `PSB_CLK_MHZ + 999) / 1000;
  localparam [31:0] CPH_CYC = (CPH_RAW < 1) ? 1 : CPH_RAW;
  localparam [31:0] REF_CYC = REFRESH_CYC;
  localparam [15:0] CEM_LIM = CEM_CYC[15:0];
  localparam [15:0] CPH_LIM = CPH_CYC[15:0];
  localparam [15:0] REF_LIM = REF_CYC[15:0];

  // Pin synchroniser
  wire [23:0] pin_raw;
  reg [23:0] s1_r;
  reg [23:0] s2_r;
  assign pin_raw = {dq_i, mem_addr_i, mem_oe_n_i, mem_we_n_i, addr_valid_n_i, mem_ce_n_i};

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s1_r <= `PSB_PIN_RST;
      s2_r <= `PSB_PIN_RST;
    end else if (clk_en_i) begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
    end
  end

  wire ce_n = s2_r[`PSB_P_CE];
  wire av_n = s2_r[`PSB_P_AV];
  wire we_n = s2_r[`PSB_P_WE];
  wire oe_n = s2_r[`PSB_P_OE];
  wire [3:0] pin_addr = s2_r[`PSB_P_A_HI:`PSB_P_A_LO];
  wire [15:0] pin_data = s2_r[`PSB_P_D_HI:`PSB_P_D_LO];

  // Control state
  reg [15:0] cfg_r;
  reg [3:0] err_r;
  reg [1:0] st_r;
  reg [4:0] lat_r;
  reg wr_r;
  reg first_r;
  reg [3:0] addr_r;
  reg [2:0] last_r;
  reg av_prev_r;
  reg we_prev_r;
  reg ce_prev_r;
  reg cewr_r;
  reg [15:0] low_cnt_r;
  reg [15:0] high_cnt_r;
  reg [15:0] ref_cnt_r;
  reg refr_r;
  reg [15:0] mem_r [0:15];

  wire sync_mode = !cfg_r[`PSB_CFG_OPMODE];
  wire fixed = cfg_r[`PSB_CFG_FIXED];
  wire [2:0] lcode = cfg_r[`PSB_CFG_LC_HI:`PSB_CFG_LC_LO];
  wire [4:0] lat_base = {2'b00, lcode} + (fixed ? `PSB_LAT_FIX_ADD : `PSB_LAT_VAR_ADD);
  wire [4:0] lat_rd = (refr_r && !fixed) ? {lat_base[3:0], 1'b0} : lat_base;
  wire [4:0] lat_wr = (lcode == 3'h0) ? 5'h01 : {2'b00, lcode};

  wire start = !ce_n && !av_n && av_prev_r && sync_mode;
  wire start_wr = !we_n;
  wire start_wr_burst = (st_r != `PSB_S_IDLE) && wr_r;
  wire awr_ev = !ce_n && av_n && !we_n && we_prev_r && !start_wr_burst;
  wire ard_ev = !ce_n && !oe_n && (st_r == `PSB_S_IDLE) && (last_r != `PSB_OP_ARD);

  wire bad_var = !fixed && ((last_r == `PSB_OP_AWR) || (last_r == `PSB_OP_ARD));
  wire bad_fix = fixed && ((last_r == `PSB_OP_ARD) || ((last_r == `PSB_OP_AWR) && start_wr));
  wire busy = (st_r != `PSB_S_IDLE);
  wire intr_early = busy && !first_r;
  wire start_ok = start && !bad_var && !bad_fix && !intr_early;
  wire awr_ok = awr_ev && ((last_r == `PSB_OP_NONE) || (last_r == `PSB_OP_AWR) ||
                (last_r == `PSB_OP_BRD_FIX));

  // Read data buffer
  wire rd_phase = (st_r == `PSB_S_DATA) && !wr_r;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [15:0] buf_out_data;
  wire buf_pop_rdy = rd_phase && !oe_n;
  wire buf_flush = ce_n || start_ok;
  wire push = rd_phase && buf_in_ready;
  wire pop = buf_pop_rdy && buf_out_valid;

  psb_wbuf u_buf (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .flush_i(buf_flush),
    .in_valid_i(rd_phase),
    .in_ready_o(buf_in_ready),
    .in_data_i(mem_r[addr_r]),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop_rdy),
    .out_data_o(buf_out_data)
  );

  // Error flag sources
  wire [3:0] err_set;
  wire [3:0] err_clr;
  assign err_set[`PSB_ST_CEM] = !ce_n && (low_cnt_r == CEM_LIM);
  assign err_set[`PSB_ST_CPH] = !ce_n && ce_prev_r && cewr_r && (high_cnt_r < CPH_LIM);
  assign err_set[`PSB_ST_TRANS] = (start && (bad_var || bad_fix)) || (awr_ev && !awr_ok);
  assign err_set[`PSB_ST_INTR] = start && intr_early;
  assign err_clr = (reg_wr_i && (reg_addr_i == `PSB_REG_STAT)) ?
                   reg_wdata_i[`PSB_ST_ERR_W-1:0] : 4'h0;

  // Wait level
  wire wait_act = (st_r == `PSB_S_LAT) &&
                  !(cfg_r[`PSB_CFG_WEARLY] && (lat_r == 5'h01));
  wire wait_lvl = cfg_r[`PSB_CFG_WPOL] ? wait_act : !wait_act;

  // Flop array
  always @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      if (awr_ok) begin
        mem_r[pin_addr] <= pin_data;
      end else if ((st_r == `PSB_S_DATA) && wr_r && !ce_n) begin
        mem_r[addr_r] <= pin_data;
      end
    end
  end

  // Burst state machine
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r <= `PSB_S_IDLE;
      lat_r <= 5'h00;
      wr_r <= 1'b0;
      first_r <= 1'b0;
      addr_r <= 4'h0;
      last_r <= `PSB_OP_NONE;
    end else if (clk_en_i) begin
      if (ce_n) begin
        st_r <= `PSB_S_IDLE;
        first_r <= 1'b0;
        last_r <= `PSB_OP_NONE;
      end else if (start_ok) begin
        st_r <= `PSB_S_LAT;
        wr_r <= start_wr;
        first_r <= 1'b0;
        addr_r <= pin_addr;
        lat_r <= start_wr ? lat_wr : lat_rd;
        last_r <= (fixed && !start_wr) ? `PSB_OP_BRD_FIX : `PSB_OP_BURST;
      end else if (awr_ok) begin
        st_r <= `PSB_S_IDLE;
        last_r <= `PSB_OP_AWR;
      end else if (ard_ev) begin
        last_r <= `PSB_OP_ARD;
      end else begin
        case (st_r)
          `PSB_S_LAT: begin
            if (lat_r <= 5'h01) begin
              st_r <= `PSB_S_DATA;
            end
            lat_r <= lat_r - 5'h01;
          end
          `PSB_S_DATA: begin
            if (wr_r) begin
              addr_r <= addr_r + 4'h1;
              first_r <= 1'b1;
            end else begin
              if (push) begin
                addr_r <= addr_r + 4'h1;
              end
              if (pop) begin
                first_r <= 1'b1;
              end
            end
          end
          default: begin
            st_r <= `PSB_S_IDLE;
          end
        endcase
      end
    end
  end

  // Enable timing and refresh
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      av_prev_r <= 1'b1;
      we_prev_r <= 1'b1;
      ce_prev_r <= 1'b1;
      cewr_r <= 1'b0;
      low_cnt_r <= 16'h0000;
      high_cnt_r <= 16'h0000;
      ref_cnt_r <= 16'h0000;
      refr_r <= 1'b0;
      err_r <= 4'h0;
    end else if (clk_en_i) begin
      av_prev_r <= av_n;
      we_prev_r <= we_n;
      ce_prev_r <= ce_n;
      err_r <= (err_r & ~err_clr) | err_set;
      if (ce_n) begin
        low_cnt_r <= 16'h0000;
        if (high_cnt_r != 16'hFFFF) begin
          high_cnt_r <= high_cnt_r + 16'h0001;
        end
      end else begin
        high_cnt_r <= 16'h0000;
        if (low_cnt_r != 16'hFFFF) begin
          low_cnt_r <= low_cnt_r + 16'h0001;
        end
      end
      if (ce_n && !ce_prev_r) begin
        cewr_r <= sync_mode ? (last_r == `PSB_OP_AWR) : !we_n;
      end
      if (ce_n) begin
        refr_r <= 1'b0;
        ref_cnt_r <= 16'h0000;
      end else if (ref_cnt_r >= REF_LIM) begin
        refr_r <= 1'b1;
      end else begin
        ref_cnt_r <= ref_cnt_r + 16'h0001;
      end
    end
  end

  // Pin and register outputs
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= `PSB_CFG_RST;
      reg_rdata_o <= 16'h0000;
      dq_o <= 16'h0000;
      dq_oe_n_o <= 1'b1;
      wait_o <= 1'b1;
      wait_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      if (reg_wr_i && (reg_addr_i == `PSB_REG_CFG)) begin
        cfg_r <= reg_wdata_i;
      end
      reg_rdata_o <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `PSB_REG_CFG: begin
            reg_rdata_o <= cfg_r;
          end
          `PSB_REG_STAT: begin
            reg_rdata_o <= {8'h00, wait_act, refr_r, st_r, err_r};
          end
          default: begin
            reg_rdata_o <= 16'h0000;
          end
        endcase
      end
      if (pop) begin
        dq_o <= buf_out_data;
      end else if (!ce_n && !oe_n && !busy) begin
        dq_o <= mem_r[pin_addr];
      end
      dq_oe_n_o <= !((rd_phase && !oe_n && (first_r || pop)) ||
                     (!ce_n && !oe_n && !busy));
      wait_o <= wait_lvl;
      wait_oe_n_o <= ce_n;
    end
  end
endmodule

/* test/psb_chk_assertions.sv */
/*
  Port checker for psb_core: register port, wait and drive timing.
  Assumes the configuration changes only through the register port.
*/
`timescale 1ns/1ps
module psb_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  // Register port
  input wire [1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  // Memory pins
  input wire mem_ce_n_i,
  input wire addr_valid_n_i,
  input wire mem_we_n_i,
  input wire mem_oe_n_i,
  input wire dq_oe_n_o,
  input wire wait_o,
  input wire wait_oe_n_o
);
  reg [15:0] cfg_r;
  reg [4:0] wc_r;
  reg av_r;
  reg wb_r;
  wire act = !wait_oe_n_o && (wait_o == cfg_r[10]);
  wire fin = (wc_r != 5'h00) && !wait_oe_n_o && !act;
  wire [4:0] lv = {2'h0, cfg_r[13:11]} + 5'h02;
  wire [4:0] wl = (cfg_r[13:11] == 3'h0) ? 5'h01 : {2'h0, cfg_r[13:11]};
  // Shadow config and wait run length
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= 16'h9800;
      wc_r <= 5'h00;
      av_r <= 1'b1;
      wb_r <= 1'b0;
    end else if (clk_en_i) begin
      if (reg_wr_i && reg_addr_i == 2'h0)
        cfg_r <= reg_wdata_i;
      av_r <= addr_valid_n_i;
      if (av_r && !addr_valid_n_i)
        wb_r <= !mem_we_n_i;
      wc_r <= act ? wc_r + 5'h01 : 5'h00;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(a);
    clk_en_i && reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_ce4;
    !mem_ce_n_i [*4];
  endsequence
  sequence s_oe4;
    mem_oe_n_i [*4];
  endsequence
  property p_rst;
    $fell(sys_rst_i) |-> dq_oe_n_o && wait_oe_n_o && reg_rdata_o == 16'h0000;
  endproperty
  property p_idle;
    clk_en_i && !reg_rd_i |=> reg_rdata_o == 16'h0000;
  endproperty
  property p_unm;
    clk_en_i && reg_rd_i && reg_addr_i[1] |=> reg_rdata_o == 16'h0000;
  endproperty
  property p_cfg;
    s_rd(2'h0) |=> reg_rdata_o == cfg_r;
  endproperty
  property p_ceoe;
    s_ce4 |-> !wait_oe_n_o;
  endproperty
  property p_oe;
    s_oe4 |-> dq_oe_n_o;
  endproperty
  property p_wlat;
    fin && wb_r && !cfg_r[8] |-> wc_r == wl;
  endproperty
  property p_vlat;
    fin && !wb_r && !cfg_r[14] && !cfg_r[8] |-> wc_r == lv || wc_r == lv + lv;
  endproperty
  property p_flat;
    fin && !wb_r && cfg_r[14] && !cfg_r[8] |-> wc_r == lv - 5'h01;
  endproperty
  property p_cap;
    act |-> wc_r < lv + lv;
  endproperty
  property p_data;
    $fell(dq_oe_n_o) |-> !act;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  a_idle: assert property (p_idle) else $error("read data not zero");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_cfg: assert property (p_cfg) else $error("config readback wrong");
  a_ceoe: assert property (p_ceoe) else $error("wait not driven");
  a_oe: assert property (p_oe) else $error("data driven with oe high");
  a_wlat: assert property (p_wlat) else $error("write wait length");
  a_vlat: assert property (p_vlat) else $error("read wait length");
  a_flat: assert property (p_flat) else $error("fixed wait length");
  a_cap: assert property (p_cap) else $error("wait too long");
  a_data: assert property (p_data) else $error("wait during data");
endmodule
bind psb_core psb_chk u_chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mem_ce_n_i, .addr_valid_n_i,
  .mem_we_n_i, .mem_oe_n_i, .dq_oe_n_o, .wait_o, .wait_oe_n_o);

/* test/psb_ctl_model.sv */
/*
  Memory controller model driving the pseudo-SRAM pins.
  Assumes every ref_clk_i cycle is a burst clock, wait active low.
*/
`timescale 1ns/1ps
module psb_ctl_model (
  // Clock and wait
  input wire ref_clk_i,
  input wire wait_i,
  // Pins to device
  output reg ce_n_o = 1'b1,
  output reg av_n_o = 1'b1,
  output reg we_n_o = 1'b1,
  output reg oe_n_o = 1'b1,
  output reg [3:0] addr_o = 4'h0,
  output reg [15:0] dq_o = 16'h0000
);
  reg brst_r = 1'b0;
  always @(posedge ref_clk_i) begin
    if (wait_i && brst_r)
      dq_o <= dq_o + 16'h1357;
  end
  task automatic rest();
    @(posedge ref_clk_i);
    ce_n_o <= 1'b1;
    av_n_o <= 1'b1;
    we_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic burst(input bit wr, input int hold);
    @(posedge ref_clk_i);
    ce_n_o <= 1'b0;
    av_n_o <= 1'b0;
    we_n_o <= !wr;
    oe_n_o <= wr;
    brst_r <= wr;
    addr_o <= addr_o + 4'h1;
    @(posedge ref_clk_i);
    av_n_o <= 1'b1;
    repeat (hold) @(posedge ref_clk_i);
  endtask
  task automatic awrite();
    @(posedge ref_clk_i);
    ce_n_o <= 1'b0;
    av_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    we_n_o <= 1'b0;
    brst_r <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    we_n_o <= 1'b1;
  endtask
  task automatic aread();
    @(posedge ref_clk_i);
    ce_n_o <= 1'b0;
    av_n_o <= 1'b1;
    we_n_o <= 1'b1;
    oe_n_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule

/* test/test_psb_burst_transition_rules.sv */
/*
  Self-checking bench for psb_core with a controller model.
  Assumes shortened MAX_ENABLE_LOW_TIME_NS and REFRESH_CYC parameters.
*/
`timescale 1ns/1ps
module test_psb_burst_transition_rules;
  reg ref_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [1:0] reg_addr_i = 2'h0;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg clk_en_i = 1'b1;
  wire [15:0] reg_rdata_o, dq_o, dq_i, mdq;
  wire dq_oe_n_o, wait_o, wait_oe_n_o;
  wire mem_ce_n_i, addr_valid_n_i, mem_we_n_i, mem_oe_n_i;
  wire [3:0] mem_addr_i;
  int mismatches = 0;
  int total_checks = 0;
  logic [15:0] nw, nd, d;
  always #12.5 ref_clk_i = ~ref_clk_i;
  // Shared data wire
  assign dq_i = dq_oe_n_o ? mdq : dq_o;
  psb_core #(.MAX_ENABLE_LOW_TIME_NS(200), .REFRESH_CYC(8)) uut (.ref_clk_i, .sys_rst_i,
    .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .mem_ce_n_i, .addr_valid_n_i, .mem_we_n_i, .mem_oe_n_i, .mem_addr_i, .dq_i,
    .dq_o, .dq_oe_n_o, .wait_o, .wait_oe_n_o);
  psb_ctl_model ctl (.ref_clk_i, .wait_i(wait_o), .ce_n_o(mem_ce_n_i),
    .av_n_o(addr_valid_n_i), .we_n_o(mem_we_n_i), .oe_n_o(mem_oe_n_i),
    .addr_o(mem_addr_i), .dq_o(mdq));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic stat(input string nm, input logic [3:0] e);
    rd(2'h1);
    chk(nm, {12'h000, e}, {12'h000, d[3:0]});
    wr(2'h1, 16'h000F);
  endtask
  task automatic meas(input int n);
    nw = 16'h0000;
    nd = 16'h0000;
    repeat (n) begin
      @(posedge ref_clk_i);
      #1;
      if (wait_oe_n_o === 1'b0 && wait_o === 1'b0) nw++;
      if (dq_oe_n_o === 1'b0) nd++;
    end
  endtask
  task automatic t_regs();
    rd(2'h0);
    chk("cfg_rst", 16'h9800, d);
    rd(2'h3);
    chk("unmapped", 16'h0000, d);
    wr(2'h0, 16'h1000);
    rd(2'h0);
    chk("cfg", 16'h1000, d);
    $display("test regs done");
  endtask
  task automatic t_bursts();
    ctl.burst(0, 0);
    meas(20);
    ctl.rest();
    chk("rd_wait", 16'h0004, nw);
    chk("rd_drive", 16'h0001, {15'h0000, nd != 16'h0000});
    stat("cem", 4'h1);
    ctl.burst(1, 0);
    meas(20);
    ctl.rest();
    chk("wr_wait", 16'h0002, nw);
    stat("wr_stat", 4'h1);
    $display("test bursts done");
  endtask
  task automatic t_intr();
    ctl.burst(0, 0);
    ctl.burst(0, 0);
    meas(20);
    ctl.rest();
    stat("early", 4'h9);
    ctl.burst(0, 12);
    ctl.burst(0, 0);
    meas(20);
    ctl.rest();
    chk("late_wait", 16'h0008, nw);
    stat("late", 4'h1);
    $display("test interrupt done");
  endtask
  task automatic t_trans();
    ctl.awrite();
    ctl.burst(0, 0);
    meas(12);
    ctl.rest();
    stat("to_var", 4'h5);
    wr(2'h0, 16'h5000);
    ctl.awrite();
    ctl.burst(0, 0);
    meas(12);
    chk("fix_wait", 16'h0003, nw);
    ctl.awrite();
    ctl.rest();
    stat("chain", 4'h1);
    $display("test transitions done");
  endtask
  task automatic t_data();
    ctl.burst(1, 2);
    ctl.rest();
    ctl.awrite();
    ctl.rest();
    ctl.aread();
    #1;
    chk("async_data", mdq, dq_o);
    chk("async_drive", 16'h0000, {15'h0000, dq_oe_n_o});
    ctl.rest();
    stat("async", 4'h0);
    $display("test async data done");
  endtask
  task automatic t_hold();
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(2'h0, 16'h0000);
    @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    rd(2'h0);
    chk("hold_cfg", 16'h5000, d);
    $display("test hold done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_bursts();
    t_intr();
    t_trans();
    t_data();
    t_hold();
    close_out();
  end
  // Tests need about 260 cycles
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    mismatches++;
    close_out();
  end
endmodule
